// ===== design/bbi_flag.sv
// package of the baseband interrupt block and its sticky source-flag cell.
// assumes one clock, an asynchronous active-high reset and a clock enable.

// ==========================================================================
// package
package bbi_pkg;
	localparam int NUM_SRC = 29;

	// flag bit positions
	localparam int B_TCMP0 = 0;
	localparam int B_CAL = 3;
	localparam int B_TXB0 = 4;
	localparam int B_TXB1 = 5;
	localparam int B_SYNC_TX = 6;
	localparam int B_CSMA = 7;
	localparam int B_RXB0 = 8;
	localparam int B_RXB1 = 9;
	localparam int B_FLEN = 10;
	localparam int B_ADDR = 11;
	localparam int B_OVR = 12;
	localparam int B_MSW = 13;
	localparam int B_RXLVL = 14;
	localparam int B_TXDONE = 15;
	localparam int B_TXCNT = 16;
	localparam int B_TXSTART = 17;
	localparam int B_RXSTART = 18;
	localparam int B_RXDONE = 19;
	localparam int B_RXCNT = 20;
	localparam int B_AGC = 21;
	localparam int B_CCA = 22;
	localparam int B_PREAMB = 23;
	localparam int B_CARRIER = 24;
	localparam int B_CCALIM = 25;
	localparam int B_CCACLR = 26;
	localparam int B_RXTMO = 27;
	localparam int B_UNDR = 28;

	// register byte offsets
	localparam logic [7:0] A_FLAGS = 8'h00;
	localparam logic [7:0] A_SRC_EN = 8'h04;
	localparam logic [7:0] A_OUT_EN = 8'h08;
	localparam logic [7:0] A_CTRL = 8'h0c;
	localparam logic [7:0] A_CMP0_LO = 8'h10;
	localparam logic [7:0] A_TIMER = 8'h28;
	localparam logic [7:0] A_TXCNT = 8'h2c;
	localparam logic [7:0] A_RXCNT = 8'h30;
	localparam logic [7:0] A_CCALIM = 8'h34;
	localparam logic [7:0] A_STATUS = 8'h38;

	// control register fields
	localparam int C_POL = 0;
	localparam int C_SEL_LO = 4;
	localparam int C_SEL_W = 4;
	localparam int C_AUTO_ACK_RX = 8;
	localparam int C_AUTO_ACK_REPLY = 9;
	localparam int C_CCA_CONT = 10;
	localparam int C_RXTMO_EN = 11;
	localparam int CTRL_W = 12;
	localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;

	localparam int NUM_PINS = 13;
	localparam int NUM_CMP = 3;
	localparam int CMP_HALF = 16;
	localparam int CNT_W = 16;
	localparam int CCA_W = 8;

	// baseband events, all one-cycle pulses on ref_clk_i, except ack_req
	typedef struct packed {
		logic cal_done;
		logic [1:0] tx_bank_sent;
		logic sync_sent;
		logic csma_done;
		logic [1:0] rx_bank_full;
		logic [1:0] rx_bank_release;
		logic [1:0] rx_restart;
		logic len_rcvd;
		logic addr_match;
		logic ms_rcvd;
		logic rx_level_err;
		logic tx_frame_end;
		logic tx_ack_req;
		logic ack_rcvd;
		logic ack_timeout;
		logic tx_byte;
		logic tx_trigger;
		logic sfd_det;
		logic rx_frame_end;
		logic rx_ack_req;
		logic ack_reply_done;
		logic rx_byte;
		logic agc_done;
		logic cca_done;
		logic cca_clear;
		logic preamble;
		logic carrier;
		logic rxtmo_start;
		logic rxtmo_expire;
		logic tx_fetch_unwritten;
	} bbi_evt_t;
endpackage : bbi_pkg

// ==========================================================================
// sticky flag cell
module bbi_flag (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic src_en_i,
	input wire logic event_i,
	input wire logic rd_clr_i,
	output logic flag_o
);
	// set wins over a read-clear in the same cycle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (ce_i) begin
			if (event_i && src_en_i) begin
				flag_o <= 1'b1;
			end else if (rd_clr_i && flag_o) begin
				flag_o <= 1'b0;
			end
		end
	end
endmodule : bbi_flag

// ===== design/bbi_top.sv
// baseband interrupt sources: sticky flags, enables and the irq pin.
// assumes events come from baseband logic on ref_clk_i; apb on same clock.
//
// What this block does
// - three timer compare channel events
// - per-bank transmit RAM sent event
// - sync portion transmitted event
// - csma-ca sequence end event
// - per-bank receive RAM full event
// - frame length received event
// - address match event, may be absent
// - restart into still-full bank: overrun
// - mode switch frame received event
// - reception communication error event
// - tx done, after ack when awaited
// - programmed tx byte count reached
// - host transmit trigger event
// - frame sync detected event
// - rx done, after ack reply if due
// - programmed rx byte count reached
// - cca done and agc done events
// - preamble and carrier sense events
// - consecutive cca limit in continuous mode
// - channel found clear event
// - receive timeout with no frame
// - transmit underrun event
// - flags set by event, cleared by read
// - irq asserted while enabled flag set
// - polarity bit selects active level
// - irq routed to one of thirteen pins
//
// The APB interface to the registers and the register addresses are this design's own decisions.

module bbi_top #(
	parameter int NUM_PINS = bbi_pkg::NUM_PINS
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire bbi_pkg::bbi_evt_t evt_i,
	output logic [NUM_PINS-1:0] irq_pin_o,
	output logic [NUM_PINS-1:0] irq_pin_oe_o
);
	localparam int NS = bbi_pkg::NUM_SRC;
	localparam int HW = bbi_pkg::CMP_HALF;

	logic [NS-1:0] flags;
	logic [NS-1:0] src_en;
	logic [NS-1:0] out_en;
	logic [NS-1:0] events;
	logic [bbi_pkg::CTRL_W-1:0] ctrl;
	logic [HW-1:0] cmp [2*bbi_pkg::NUM_CMP];
	logic [31:0] timer;
	logic [bbi_pkg::CNT_W-1:0] tx_target;
	logic [bbi_pkg::CNT_W-1:0] rx_target;
	logic [bbi_pkg::CNT_W-1:0] tx_count;
	logic [bbi_pkg::CNT_W-1:0] rx_count;
	logic [bbi_pkg::CCA_W-1:0] cca_limit;
	logic [bbi_pkg::CCA_W-1:0] cca_count;
	logic [1:0] bank_full;
	logic ack_wait_tx;
	logic ack_wait_rx;
	logic frame_seen;
	logic tx_cnt_ev;
	logic rx_cnt_ev;
	logic cca_lim_ev;
	logic [bbi_pkg::NUM_CMP-1:0] cmp_ev;
	logic wr_acc;
	logic rd_cap;
	logic rd_flags;
	logic [31:0] next_rdata;
	logic next_err;
	logic irq_active;
	logic [bbi_pkg::C_SEL_W-1:0] pin_sel;

	// ======================================================================
	// apb slave
	// one wait state: pready rises on the first access cycle's edge
	assign rd_cap = psel && penable && !pready;
	assign wr_acc = psel && penable && pready && pwrite;
	assign rd_flags = rd_cap && !pwrite && (paddr == bbi_pkg::A_FLAGS);

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		case (paddr)
			bbi_pkg::A_FLAGS: next_rdata[NS-1:0] = flags;
			bbi_pkg::A_SRC_EN: next_rdata[NS-1:0] = src_en;
			bbi_pkg::A_OUT_EN: next_rdata[NS-1:0] = out_en;
			bbi_pkg::A_CTRL: next_rdata[bbi_pkg::CTRL_W-1:0] = ctrl;
			bbi_pkg::A_TIMER: next_rdata = timer;
			bbi_pkg::A_TXCNT: next_rdata[bbi_pkg::CNT_W-1:0] = tx_target;
			bbi_pkg::A_RXCNT: next_rdata[bbi_pkg::CNT_W-1:0] = rx_target;
			bbi_pkg::A_CCALIM: next_rdata[bbi_pkg::CCA_W-1:0] = cca_limit;
			bbi_pkg::A_STATUS: next_rdata[1:0] = bank_full;
			default: begin
				if (paddr >= bbi_pkg::A_CMP0_LO && paddr < bbi_pkg::A_TIMER
						&& paddr[1:0] == 2'b00) begin
					next_rdata[HW-1:0] =
						cmp[3'(paddr[4:2] - bbi_pkg::A_CMP0_LO[4:2])];
				end else begin
					next_err = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce_i) begin
			pready <= rd_cap;
			pslverr <= rd_cap && next_err;
			if (rd_cap && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// ======================================================================
	// software registers
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			src_en <= '0;
			out_en <= '0;
			ctrl <= bbi_pkg::CTRL_RST;
			tx_target <= '0;
			rx_target <= '0;
			cca_limit <= '0;
			for (int i = 0; i < 2*bbi_pkg::NUM_CMP; i++) begin
				cmp[i] <= '0;
			end
		end else if (ce_i && wr_acc) begin
			case (paddr)
				bbi_pkg::A_SRC_EN: src_en <= pwdata[NS-1:0];
				bbi_pkg::A_OUT_EN: out_en <= pwdata[NS-1:0];
				bbi_pkg::A_CTRL: ctrl <= pwdata[bbi_pkg::CTRL_W-1:0];
				bbi_pkg::A_TXCNT: tx_target <= pwdata[bbi_pkg::CNT_W-1:0];
				bbi_pkg::A_RXCNT: rx_target <= pwdata[bbi_pkg::CNT_W-1:0];
				bbi_pkg::A_CCALIM: cca_limit <= pwdata[bbi_pkg::CCA_W-1:0];
				default: begin
					if (!next_err && paddr >= bbi_pkg::A_CMP0_LO
							&& paddr < bbi_pkg::A_TIMER) begin
						cmp[3'(paddr[4:2] - bbi_pkg::A_CMP0_LO[4:2])] <=
							pwdata[HW-1:0];
					end
				end
			endcase
		end
	end

	// ======================================================================
	// free-running timer and compares
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer <= 32'h0000_0000;
		end else if (ce_i) begin
			timer <= timer + 32'h0000_0001;
		end
	end

	for (genvar c = 0; c < bbi_pkg::NUM_CMP; c++) begin : g_cmp
		assign cmp_ev[c] = (timer == {cmp[2*c+1], cmp[2*c]});
	end

	// ======================================================================
	// byte counters
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_count <= '0;
		end else if (ce_i) begin
			if (evt_i.tx_trigger) begin
				tx_count <= '0;
			end else if (evt_i.tx_byte) begin
				tx_count <= tx_count + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_count <= '0;
		end else if (ce_i) begin
			if (evt_i.sfd_det) begin
				rx_count <= '0;
			end else if (evt_i.rx_byte) begin
				rx_count <= rx_count + 1'b1;
			end
		end
	end

	// fire on the byte that makes the count equal the target
	assign tx_cnt_ev = evt_i.tx_byte && !evt_i.tx_trigger
		&& (tx_count + 1'b1 == tx_target);
	assign rx_cnt_ev = evt_i.rx_byte && !evt_i.sfd_det
		&& (rx_count + 1'b1 == rx_target);

	// ======================================================================
	// consecutive cca count
	assign cca_lim_ev = ctrl[bbi_pkg::C_CCA_CONT] && evt_i.cca_done
		&& (cca_count + 1'b1 == cca_limit);

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cca_count <= '0;
		end else if (ce_i) begin
			if (!ctrl[bbi_pkg::C_CCA_CONT] || cca_lim_ev) begin
				cca_count <= '0;
			end else if (evt_i.cca_done) begin
				cca_count <= cca_count + 1'b1;
			end
		end
	end

	// ======================================================================
	// receive bank status and ack waits
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bank_full <= 2'b00;
		end else if (ce_i) begin
			bank_full <= evt_i.rx_bank_full
				| (bank_full & ~evt_i.rx_bank_release);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_wait_tx <= 1'b0;
		end else if (ce_i) begin
			if (evt_i.tx_frame_end && evt_i.tx_ack_req
					&& ctrl[bbi_pkg::C_AUTO_ACK_RX]) begin
				ack_wait_tx <= 1'b1;
			end else if (evt_i.ack_rcvd || evt_i.ack_timeout) begin
				ack_wait_tx <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_wait_rx <= 1'b0;
		end else if (ce_i) begin
			if (evt_i.rx_frame_end && evt_i.rx_ack_req
					&& ctrl[bbi_pkg::C_AUTO_ACK_REPLY]) begin
				ack_wait_rx <= 1'b1;
			end else if (evt_i.ack_reply_done) begin
				ack_wait_rx <= 1'b0;
			end
		end
	end

	// any frame received since the receive timeout was armed
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_seen <= 1'b0;
		end else if (ce_i) begin
			if (evt_i.rxtmo_start) begin
				frame_seen <= 1'b0;
			end else if (evt_i.rx_frame_end) begin
				frame_seen <= 1'b1;
			end
		end
	end

	// ======================================================================
	// event map
	always_comb begin
		events = '0;
		events[bbi_pkg::B_TCMP0 +: bbi_pkg::NUM_CMP] = cmp_ev;
		events[bbi_pkg::B_CAL] = evt_i.cal_done;
		events[bbi_pkg::B_TXB0] = evt_i.tx_bank_sent[0];
		events[bbi_pkg::B_TXB1] = evt_i.tx_bank_sent[1];
		events[bbi_pkg::B_SYNC_TX] = evt_i.sync_sent;
		events[bbi_pkg::B_CSMA] = evt_i.csma_done;
		events[bbi_pkg::B_RXB0] = evt_i.rx_bank_full[0];
		events[bbi_pkg::B_RXB1] = evt_i.rx_bank_full[1];
		events[bbi_pkg::B_FLEN] = evt_i.len_rcvd;
		events[bbi_pkg::B_ADDR] = evt_i.addr_match;
		events[bbi_pkg::B_OVR] = |(evt_i.rx_restart & bank_full);
		events[bbi_pkg::B_MSW] = evt_i.ms_rcvd;
		events[bbi_pkg::B_RXLVL] = evt_i.rx_level_err;
		events[bbi_pkg::B_TXDONE] = (evt_i.tx_frame_end
			&& !(evt_i.tx_ack_req && ctrl[bbi_pkg::C_AUTO_ACK_RX]))
			|| (ack_wait_tx && (evt_i.ack_rcvd
			|| evt_i.ack_timeout));
		events[bbi_pkg::B_TXCNT] = tx_cnt_ev;
		events[bbi_pkg::B_TXSTART] = evt_i.tx_trigger;
		events[bbi_pkg::B_RXSTART] = evt_i.sfd_det;
		events[bbi_pkg::B_RXDONE] = (evt_i.rx_frame_end
			&& !(evt_i.rx_ack_req && ctrl[bbi_pkg::C_AUTO_ACK_REPLY]))
			|| (ack_wait_rx && evt_i.ack_reply_done);
		events[bbi_pkg::B_RXCNT] = rx_cnt_ev;
		events[bbi_pkg::B_AGC] = evt_i.agc_done;
		events[bbi_pkg::B_CCA] = evt_i.cca_done;
		events[bbi_pkg::B_PREAMB] = evt_i.preamble;
		events[bbi_pkg::B_CARRIER] = evt_i.carrier;
		events[bbi_pkg::B_CCALIM] = cca_lim_ev;
		events[bbi_pkg::B_CCACLR] = evt_i.cca_clear;
		events[bbi_pkg::B_RXTMO] = ctrl[bbi_pkg::C_RXTMO_EN]
			&& evt_i.rxtmo_expire && !frame_seen;
		events[bbi_pkg::B_UNDR] = evt_i.tx_fetch_unwritten;
	end

	// ======================================================================
	// sticky flags
	for (genvar i = 0; i < NS; i++) begin : g_flag
		bbi_flag u_flag (
			.ref_clk_i(ref_clk_i),
			.rst_i(rst_i),
			.ce_i(ce_i),
			.src_en_i(src_en[i]),
			.event_i(events[i]),
			.rd_clr_i(rd_flags),
			.flag_o(flags[i])
		);
	end

	// ======================================================================
	// interrupt pin
	assign irq_active = |(flags & out_en);
	assign pin_sel = ctrl[bbi_pkg::C_SEL_LO +: bbi_pkg::C_SEL_W];

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_pin_o <= '0;
			irq_pin_oe_o <= '0;
		end else if (ce_i) begin
			for (int p = 0; p < NUM_PINS; p++) begin
				irq_pin_oe_o[p] <= (32'(pin_sel) == p);
				irq_pin_o[p] <= (32'(pin_sel) == p)
					&& (irq_active ^ ctrl[bbi_pkg::C_POL]);
			end
		end
	end
endmodule : bbi_top

// ===== tb/bbi_bb_model.sv
// baseband event source in front of the interrupt block.
// assumes one request vector from the bench per go pulse.

// ==========================================================================
// event model
module bbi_bb_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire bbi_pkg::bbi_evt_t req_i,
	output bbi_pkg::bbi_evt_t evt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// single-cycle pulses; ack request levels ride with the frame end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			evt_o <= '0;
		end else begin
			evt_o <= go_i ? req_i : '0;
		end
	end
endmodule : bbi_bb_model

// ===== tb/bbi_top_properties.sv
// checker of the baseband interrupt block, bound to its top module.
// assumes one clock domain and the ports of bbi_top.

// ==========================================================================
// checker
module bbi_top_chk #(
	parameter int NUM_PINS = bbi_pkg::NUM_PINS
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire bbi_pkg::bbi_evt_t evt_i,
	input wire logic [NUM_PINS-1:0] irq_pin_o,
	input wire logic [NUM_PINS-1:0] irq_pin_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	logic wr_ctrl;
	assign wr_ctrl = ce_i && psel && penable && pready && pwrite
		&& paddr == 8'h0c;
	function automatic logic [NUM_PINS-1:0] oe_of(input logic [31:0] w);
		return (32'(w[7:4]) < NUM_PINS) ? NUM_PINS'(1) << w[7:4] : '0;
	endfunction : oe_of

	wait_one_a: assert property (ce_i && psel && penable && !pready |=> pready)
		else $error("no ready one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_ready_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside an answer");
	unmapped_err_a: assert property (pready && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > 8'h38))
		else $error("error flag wrong for address");
	unmapped_zero_a: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!$stable(prdata)
		|-> $past(psel && penable && !pwrite && !pready))
		else $error("read data changed outside capture");
	oe_route_a: assert property (wr_ctrl
		|=> ##1 irq_pin_oe_o == oe_of($past(pwdata, 2)))
		else $error("enable not on selected pin");
	oe_onehot_a: assert property ($onehot0(irq_pin_oe_o))
		else $error("more than one pin enabled");
	pin_off_a: assert property ((irq_pin_o & ~irq_pin_oe_o) == '0)
		else $error("unselected pin driven");
	pin_cause_a: assert property (!$stable(irq_pin_o)
		|-> $past(evt_i != '0 || psel, 2))
		else $error("pin moved without cause");

	cover property (pslverr);
	cover property ($rose(irq_pin_o[0]));
	cover property (wr_ctrl);
endmodule : bbi_top_chk

bind bbi_top bbi_top_chk #(.NUM_PINS(NUM_PINS)) i_bbi_top_chk (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .evt_i(evt_i),
	.irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));

// ===== tb/bbi_top_tb_top.sv
// self-checking bench of the baseband interrupt block.
// assumes the bound checker and the event model on evt_i.
`define CHK(nm, ex, got) \
	begin \
		cmp_count++; \
		if ((got) !== (ex)) begin \
			n_fail++; \
			$display("unexpected %s exp %h got %h", nm, ex, got); \
		end \
	end

// ==========================================================================
// bench
module bbi_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic go = 1'b0;
	bbi_pkg::bbi_evt_t req = '0;
	bbi_pkg::bbi_evt_t evt;
	bbi_pkg::bbi_evt_t e;
	logic [12:0] irq_pin_o;
	logic [12:0] irq_pin_oe_o;
	logic [32:0] exp_q [$];
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	int sel;
	// flag bit, then bit of the event vector
	int tbl [21][2] = '{'{3, 33}, '{4, 31}, '{5, 32}, '{6, 30}, '{7, 29},
		'{8, 27}, '{9, 28}, '{10, 22}, '{11, 21}, '{13, 20}, '{14, 19},
		'{15, 18}, '{17, 13}, '{18, 12}, '{19, 11}, '{21, 7}, '{22, 6},
		'{23, 4}, '{24, 3}, '{26, 5}, '{28, 0}};

	always #2 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) cyc <= cyc + 1;

	bbi_top i_bbi_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .evt_i(evt), .irq_pin_o(irq_pin_o),
		.irq_pin_oe_o(irq_pin_oe_o));
	bbi_bb_model i_bbi_bb_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.go_i(go), .req_i(req), .evt_o(evt));

	// read answers against the oldest note
	always @(posedge ref_clk_i) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				n_fail++;
				$display("unexpected read exp none got %h", prdata);
			end else begin
				`CHK("prdata", exp_q[0][31:0], prdata)
				`CHK("pslverr", exp_q[0][32], pslverr)
				void'(exp_q.pop_front());
			end
		end
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk_i);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic er,
		input logic [31:0] x);
		exp_q.push_back({er, x});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic fl(input logic [31:0] x);
		rd(bbi_pkg::A_FLAGS, 1'b0, x);
	endtask : fl

	task automatic fire(input bbi_pkg::bbi_evt_t v);
		req <= v;
		go <= 1'b1;
		@(posedge ref_clk_i);
		go <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask : fire

	task automatic pin(input logic [12:0] p, input logic [12:0] oe);
		@(negedge ref_clk_i);
		`CHK("irq_pin", p, irq_pin_o)
		`CHK("irq_oe", oe, irq_pin_oe_o)
		@(posedge ref_clk_i);
	endtask : pin

	initial begin
		sel = $urandom(86770);
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		rd(bbi_pkg::A_CTRL, 1'b0, 32'h0);
		rd(bbi_pkg::A_SRC_EN, 1'b0, 32'h0);
		apb(1'b1, 8'h40, $urandom());
		rd(8'h40, 1'b1, 32'h0);
		apb(1'b1, bbi_pkg::A_SRC_EN, 32'h1fffffff);
		apb(1'b1, bbi_pkg::A_OUT_EN, 32'h1ffffff8);
		// sources driven straight by one event
		foreach (tbl[i]) begin
			pin(13'h0, 13'h1);
			fire(bbi_pkg::bbi_evt_t'(34'h1 << tbl[i][1]));
			pin(13'h1, 13'h1);
			fl(32'h1 << tbl[i][0]);
			fl(32'h0);
		end
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, bbi_pkg::A_CMP0_LO + 8'(8 * c), 32'((cyc + 40) % 65536));
			repeat (60) @(posedge ref_clk_i);
			fl(32'h1 << c);
		end
		apb(1'b1, bbi_pkg::A_SRC_EN, 32'h1fffff7f);
		e = '0;
		e.csma_done = 1'b1;
		fire(e);
		fl(32'h0);
		apb(1'b1, bbi_pkg::A_SRC_EN, 32'h1fffffff);
		// both banks are full from the loop above
		e = '0;
		e.rx_restart = 2'h1;
		fire(e);
		fl(32'h1000);
		e.rx_restart = 2'h0;
		e.rx_bank_release = 2'h1;
		fire(e);
		e = '0;
		e.rx_restart = 2'h1;
		fire(e);
		fl(32'h0);
		e.rx_restart = 2'h2;
		fire(e);
		fl(32'h1000);
		rd(bbi_pkg::A_STATUS, 1'b0, 32'h2);
		apb(1'b1, bbi_pkg::A_CTRL, 32'h300);
		e = '0;
		e.tx_frame_end = 1'b1;
		e.tx_ack_req = 1'b1;
		e.rx_frame_end = 1'b1;
		e.rx_ack_req = 1'b1;
		fire(e);
		fl(32'h0);
		e = '0;
		e.ack_timeout = 1'b1;
		e.ack_reply_done = 1'b1;
		fire(e);
		fl(32'h88000);
		apb(1'b1, bbi_pkg::A_TXCNT, 32'h3);
		apb(1'b1, bbi_pkg::A_RXCNT, 32'h2);
		e = '0;
		e.tx_trigger = 1'b1;
		e.sfd_det = 1'b1;
		fire(e);
		fl(32'h60000);
		e = '0;
		e.tx_byte = 1'b1;
		e.rx_byte = 1'b1;
		fire(e);
		fire(e);
		fl(32'h100000);
		fire(e);
		fl(32'h10000);
		apb(1'b1, bbi_pkg::A_CCALIM, 32'h2);
		apb(1'b1, bbi_pkg::A_CTRL, 32'hc00);
		e = '0;
		e.cca_done = 1'b1;
		e.rxtmo_start = 1'b1;
		fire(e);
		e.rxtmo_start = 1'b0;
		e.rxtmo_expire = 1'b1;
		fire(e);
		fl(32'ha400000);
		// an event while the clock enable is low is lost
		ce_i <= 1'b0;
		e = '0;
		e.preamble = 1'b1;
		fire(e);
		ce_i <= 1'b1;
		fl(32'h0);
		sel = 1 + $urandom_range(11);
		apb(1'b1, bbi_pkg::A_CTRL, 32'h1 | 32'(sel << 4));
		pin(13'h1 << sel, 13'h1 << sel);
		e = '0;
		e.preamble = 1'b1;
		fire(e);
		pin(13'h0, 13'h1 << sel);
		fl(32'h800000);
		pin(13'h1 << sel, 13'h1 << sel);
		apb(1'b1, bbi_pkg::A_CTRL, 32'hd0);
		pin(13'h0, 13'h0);
		close_out();
	end
endmodule : bbi_top_tb_top
